//--- dv/sfr_link_checker.sv
/* Checker of timing relations on the flash link wires.
   Assumes the bench clock and reset and the link signals. */
`timescale 1ns/1ps
`default_nettype none
module sfr_link_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Mode 0 framing keeps the clock low around select.
  sequence s_rest;
    !sck [*4];
  endsequence
  property p_sel; $fell(cs_n) |-> s_rest; endproperty
  a_sel: assert property (p_sel) else $error("clock high at select");
  property p_idle; cs_n && $past(cs_n) |-> !sck; endproperty
  a_idle: assert property (p_idle) else $error("clock while idle");
  // The synced pins take a few cycles, so the release is checked late.
  property p_desel; cs_n [*8] |-> d_io_oe == 4'h0; endproperty
  a_desel: assert property (p_desel) else $error("drive while idle");
  property p_hold_z; (!hold_n && !cs_n) [*8] |-> d_io_oe == 4'h0; endproperty
  a_hold_z: assert property (p_hold_z) else $error("drive while held");
  property p_hold_e; $changed(hold_n) |-> !sck && !$past(sck); endproperty
  a_hold_e: assert property (p_hold_e) else $error("hold moved, clock high");
  property p_hold_s; !hold_n |-> !sck; endproperty
  a_hold_s: assert property (p_hold_s) else $error("clock in pause");
  // A clash would hide the host's drive behind the device's data.
  property p_clash; (d_io_oe & h_io_oe) == 4'h0; endproperty
  a_clash: assert property (p_clash) else $error("both ends drive");
  property p_fall; $changed(d_io_o) && d_io_oe != 4'h0 |-> !sck; endproperty
  a_fall: assert property (p_fall) else $error("data moved, clock high");
endmodule
`default_nettype wire

//--- dv/sfr_tb_top.sv
/* Bench: host and device ends joined by the link, checker beside it.
   Assumes the package, interface and both ends are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module serial_flash_read_hold_logic_tb_top import sfr_pkg::*;;
  logic clk = 1'h0, nrst = 1'h0, start = 1'h0, wide_addr = 1'h0, quad = 1'h0;
  logic hold_req = 1'h0, write_busy = 1'h0, ext_addr = 1'h0, four_line = 1'h0;
  logic rd_valid, done, held, cmd_dropped;
  logic [7:0] opcode = 8'h00, rd_data, mem_data = 8'h00;
  logic [31:0] addr = 32'h0;
  logic [5:0] dummy_clks = 6'h00;
  logic [2:0] hold_off = 3'h0;
  logic [15:0] nbytes = 16'h0;
  logic [ADDR_W-1:0] mem_addr;
  int miscompares = 0, comparisons = 0, cycles = 0, drops = 0;
  sfr_link_if lk ();
  always #12.5 clk = ~clk;
  sfr_flash_dev i_sfr_flash_dev (.clk(clk), .nrst(nrst), .lk(lk.dev),
    .write_in_progress_flag(write_busy), .extended_address_flag(ext_addr),
    .four_line_command_protocol(four_line), .quad_enable_bit(hold_off[0]),
    .dtr_mode(hold_off[1]), .hold_pin_is_reset(hold_off[2]), .dummy_single(5'h08),
    .dummy_quad(5'h06),
    .mem_data(mem_data), .mem_addr(mem_addr), .mem_rd(), .cmd_dropped(cmd_dropped),
    .data_phase(), .held(held));
  sfr_flash_host i_sfr_flash_host (.clk(clk), .nrst(nrst), .lk(lk.host), .start(start),
    .opcode(opcode), .addr(addr), .wide_addr(wide_addr), .quad(quad), .dummy_clks(dummy_clks),
    .nbytes(nbytes), .hold_req(hold_req), .busy(), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .paused());
  sfr_link_checker i_sfr_link_checker (.clk(clk), .nrst(nrst), .sck(lk.sck), .cs_n(lk.cs_n),
    .hold_n(lk.hold_n), .h_io_oe(lk.h_io_oe), .d_io_o(lk.d_io_o), .d_io_oe(lk.d_io_oe));
  ////////////////////////////////////////
  // Array content mixes address bits 7..0 and 25..18 so a dropped bit there shows; bits 17..8 do not change it.
  function automatic logic [7:0] pat(input logic [25:0] a);
    pat = a[7:0] + a[25:18];
  endfunction
  // Array port, refusal counter and hang guard.
  always @(posedge clk) begin
    mem_data <= pat(mem_addr);
    cycles <= cycles + 1;
    if (cmd_dropped === 1'h1) drops <= drops + 1;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One read; bytes follow the array from the decoded address, or read as ones if refused.
  // Plain reads (bit 3 of the opcode clear) take no dummy clocks.
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input logic w, input logic q,
                    input int n, input logic ok);
    logic [25:0] e;
    int got;
    e = w ? a[25:0] : {2'h0, a[23:0]};
    got = 0;
    @(posedge clk);
    opcode <= op;
    addr <= a;
    wide_addr <= w;
    quad <= q;
    nbytes <= 16'(n);
    ext_addr <= w && op != 8'h13 && op != 8'h0C;
    dummy_clks <= op[3] ? (q ? 6'h06 : 6'h08) : 6'h00;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    while (done !== 1'h1) begin
      @(negedge clk);
      if (rd_valid === 1'h1) begin
        `CHK("rd_data", ok ? pat(e) : 8'hFF, rd_data)
        e = e + 26'h1;
        got++;
      end
    end
    @(posedge clk);
    `CHK("bytes", n, got)
  endtask
  task automatic t_single();
    rd(8'h03, 32'hFF12_3456, 1'h0, 1'h0, 3, 1'h1);
    rd(8'h03, 32'hC1FF_FFFF, 1'h1, 1'h0, 2, 1'h1);
    rd(8'h13, 32'h0200_0001, 1'h1, 1'h0, 1, 1'h1);
    rd(8'h0B, 32'h00FF_FFFF, 1'h0, 1'h0, 2, 1'h1);
    rd(8'h0C, 32'hFFFF_FFFE, 1'h1, 1'h0, 4, 1'h1);
    $display("test single done");
  endtask
  task automatic t_quad();
    four_line <= 1'h1;
    repeat (4) @(posedge clk);
    rd(8'h0B, 32'h0000_0100, 1'h0, 1'h1, 2, 1'h1);
    rd(8'h0C, 32'h0123_4567, 1'h1, 1'h1, 2, 1'h1);
    rd(8'hEB, 32'h0000_2000, 1'h0, 1'h1, 1, 1'h1);
    rd(8'h4B, 32'h0000_0030, 1'h0, 1'h1, 1, 1'h1);
    rd(8'h68, 32'h0000_0040, 1'h0, 1'h1, 1, 1'h1);
    rd(8'h03, 32'h0000_0010, 1'h0, 1'h1, 1, 1'h0);
    four_line <= 1'h0;
    repeat (4) @(posedge clk);
    $display("test quad done");
  endtask
  task automatic t_busy();
    int k;
    k = drops;
    write_busy <= 1'h1;
    rd(8'h0B, 32'h0000_0040, 1'h0, 1'h0, 2, 1'h0);
    `CHK("dropped", k + 1, drops)
    write_busy <= 1'h0;
    $display("test busy done");
  endtask
  // First pass pauses the data phase; the others pause the address with hold disabled.
  task automatic t_hold();
    for (int i = 0; i < 4; i++) begin
      hold_off <= {i == 3, i == 2, i == 1};
      fork
        rd(8'h0B, 32'h0000_0300, 1'h0, 1'h0, 3, 1'h1);
        begin
          repeat (i == 0 ? 900 : 300) @(posedge clk);
          hold_req <= 1'h1;
          repeat (60) @(negedge clk);
          `CHK("held", i == 0, held)
          `CHK("oe", 4'h0, lk.d_io_oe)
          @(posedge clk);
          hold_req <= 1'h0;
        end
      join
    end
    $display("test hold done");
  endtask
  // Reset, then every test in turn.
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    repeat (4) @(posedge clk);
    t_single();
    t_quad();
    t_busy();
    t_hold();
    finish_test();
  end
endmodule
`default_nettype wire

//--- src/sfr_flash_dev.sv
/*
  Device end of the serial flash link: command, address, dummy and data phases
  of the array reads, plus the hold pause. Array bytes come from a memory port.
  Assumes the memory answers one clk after mem_rd, and that the link pins are
  asynchronous to clk and change no faster than every few clk periods.
*/
// The register offsets and the plain strobed port were left to the implementer.
// Overview of operation
// - plain read: flag picks 3/4 bytes; wide opcode 4.
// - host shifts opcode then address on line 0.
// - decode bits 23..0 or 25..0 only.
// - after address, data-in line is ignored.
// - single-line data out on line 1, MSB first.
// - address steps by one after each byte.
// - past top of array address wraps to zero.
// - host ends a read by deselecting.
// - reads refused while a write is in progress.
// - dummy read: flag picks 3/4 bytes; wide opcode 4.
// - dummy read samples line 0 on rising clock.
// - dummy read data changes on falling clock.
// - four-line: opcode 2 clocks, address 6/8 clocks.
// - four-line dummy period follows, default six.
// - four-line data on all lines, falling edges.
// - quad, id and info-row reads use four-line framing.
// - hold pauses only while selected, keeps state.
// - host lowers hold only while clock low.
// - host raises hold while clock low; no advance.
// - held device floats output, ignores input.
// - hold off in double-rate, quad-enable or reset-pin use.
`timescale 1ns/1ps
`default_nettype none

module sfr_flash_dev import sfr_pkg::*; #(
  parameter int DUMMY_W = 5
) (
  input wire logic clk,
  input wire logic nrst,
  sfr_link_if.dev lk,
  input wire logic write_in_progress_flag,
  input wire logic extended_address_flag,
  input wire logic four_line_command_protocol,
  input wire logic quad_enable_bit,
  input wire logic dtr_mode,
  input wire logic hold_pin_is_reset,
  input wire logic [DUMMY_W-1:0] dummy_single,
  input wire logic [DUMMY_W-1:0] dummy_quad,
  input wire logic [7:0] mem_data,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic cmd_dropped,
  output logic data_phase,
  output logic held
);

  // Elaboration check: the dummy count must fit the six-bit phase counter.
  if (DUMMY_W < 4 || DUMMY_W > 6) begin : g_bad_dummy_w
    $error("DUMMY_W must be 4 to 6");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [6:0] s_pins;
  logic s_sck;
  logic s_cs_n;
  logic s_hold_n;
  logic [3:0] s_io;
  logic sck_rise;
  logic sck_fall;
  logic hold_ok;

  // Reset values match the idle pins, so no false clock edge follows reset.
  sfr_sync #(.W(7), .INIT(7'h3F)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({lk.sck, lk.cs_n, lk.hold_n, lk.io}),
    .q(s_pins)
  );

  assign s_sck = s_pins[6];
  assign s_cs_n = s_pins[5];
  assign s_hold_n = s_pins[4];
  assign s_io = s_pins[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  sfr_dev_st_t state_reg, state_next;
  logic sck_prev_reg, sck_prev_next;
  logic hold_reg, hold_next;
  logic quad_reg, quad_next;
  logic fast_reg, fast_next;
  logic wide_reg, wide_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] dmy_reg, dmy_next;
  logic [31:0] sh_reg, sh_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [ADDR_W-1:0] maddr_reg, maddr_next;
  logic mrd_reg, mrd_next;
  logic pend_reg, pend_next;
  logic [7:0] byte_reg, byte_next;
  logic [7:0] sr_reg, sr_next;
  logic [2:0] bcnt_reg, bcnt_next;
  logic started_reg, started_next;
  logic [3:0] out_reg, out_next;
  logic [3:0] oe_reg, oe_next;
  logic drop_reg, drop_next;
  logic [31:0] sh_in;
  logic [7:0] cur;
  logic ok_c;
  logic fast_c;
  logic wide_c;

  assign sck_rise = s_sck & ~sck_prev_reg;
  assign sck_fall = ~s_sck & sck_prev_reg;
  assign hold_ok = ~dtr_mode & ~quad_enable_bit & ~hold_pin_is_reset;

  // Next-state logic; a deselect overrides everything and restarts the framing.
  always_comb begin
    state_next = state_reg;
    sck_prev_next = s_sck;
    hold_next = hold_reg;
    quad_next = quad_reg;
    fast_next = fast_reg;
    wide_next = wide_reg;
    cnt_next = cnt_reg;
    dmy_next = dmy_reg;
    sh_next = sh_reg;
    addr_next = addr_reg;
    maddr_next = maddr_reg;
    mrd_next = 1'b0;
    pend_next = mrd_reg;
    byte_next = byte_reg;
    sr_next = sr_reg;
    bcnt_next = bcnt_reg;
    started_next = started_reg;
    out_next = out_reg;
    drop_next = 1'b0;
    ok_c = 1'b0;
    fast_c = 1'b0;
    wide_c = 1'b0;
    cur = (bcnt_reg == 3'h0) ? byte_reg : sr_reg;
    sh_in = quad_reg ? {sh_reg[27:0], s_io} : {sh_reg[30:0], s_io[0]};
    // hold level taken only with clock low
    if (!s_sck) begin
      hold_next = hold_ok & ~s_hold_n & ~s_cs_n;
    end
    if (pend_reg) begin
      byte_next = mem_data;
    end
    if (s_cs_n) begin
      state_next = SFR_D_CMD;
      cnt_next = 6'h00;
      bcnt_next = 3'h0;
      started_next = 1'b0;
      hold_next = 1'b0;
      quad_next = four_line_command_protocol;
    end else if (!hold_reg) begin
      case (state_reg)
        SFR_D_CMD: begin
          // opcode in two clocks on four lines
          if (sck_rise) begin
            sh_next = sh_in;
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == link_clks(quad_reg, CMD_BITS) - 6'h01) begin
              case (sh_in[7:0])
                plain_array_read_cmd: begin
                  ok_c = ~quad_reg;
                  wide_c = extended_address_flag;
                end
                plain_array_read_wide_addr_cmd: begin
                  ok_c = ~quad_reg;
                  wide_c = 1'b1;
                end
                dummy_cycle_array_read_cmd: begin
                  ok_c = 1'b1;
                  fast_c = 1'b1;
                  wide_c = extended_address_flag;
                end
                dummy_cycle_array_read_wide_addr_cmd: begin
                  ok_c = 1'b1;
                  fast_c = 1'b1;
                  wide_c = 1'b1;
                end
                quad_io_array_read_cmd: begin
                  ok_c = quad_reg;
                  fast_c = 1'b1;
                  wide_c = extended_address_flag;
                end
                unique_id_read_cmd, info_row_read_cmd: begin
                  ok_c = quad_reg;
                  fast_c = 1'b1;
                end
                default: ok_c = 1'b0;
              endcase
              fast_next = fast_c;
              wide_next = wide_c;
              cnt_next = 6'h00;
              if (!ok_c || write_in_progress_flag) begin
                state_next = SFR_D_IGNORE;
                drop_next = 1'b1;
              end else begin
                state_next = SFR_D_ADDR;
              end
            end
          end
        end
        SFR_D_ADDR: begin
          if (sck_rise) begin
            sh_next = sh_in;
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == link_clks(quad_reg, wide_reg ? WIDE_ADDR_BITS : SHORT_ADDR_BITS)
                - 6'h01) begin
              addr_next = addr_mask(wide_reg, sh_in);
              cnt_next = 6'h00;
              dmy_next = quad_reg ? 6'(dummy_quad) : 6'(dummy_single);
              if (fast_reg && dmy_next != 6'h00) begin
                state_next = SFR_D_DUMMY;
              end else begin
                state_next = SFR_D_DATA;
              end
              mrd_next = 1'b1;
              maddr_next = addr_next;
            end
          end
        end
        SFR_D_DUMMY: begin
          if (sck_rise) begin
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == dmy_reg - 6'h01) begin
              state_next = SFR_D_DATA;
            end
          end
        end
        SFR_D_DATA: begin
          if (sck_fall) begin
            started_next = 1'b1;
            out_next = quad_reg ? cur[7:4] : {2'b00, cur[7], 1'b0};
            sr_next = quad_reg ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
            bcnt_next = (bcnt_reg == (quad_reg ? 3'h1 : 3'h7)) ? 3'h0 : bcnt_reg + 3'h1;
            if (bcnt_reg == 3'h0) begin
              addr_next = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
              mrd_next = 1'b1;
              maddr_next = addr_next;
            end
          end
        end
        SFR_D_IGNORE: begin
          state_next = SFR_D_IGNORE;
        end
        default: state_next = SFR_D_IGNORE;
      endcase
    end
    oe_next = (state_next == SFR_D_DATA && started_next && !hold_next && !s_cs_n)
              ? (quad_reg ? 4'hF : 4'h2) : 4'h0;
  end

  // Registers only; everything is computed above.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= SFR_D_CMD;
      sck_prev_reg <= 1'b0;
      hold_reg <= 1'b0;
      quad_reg <= 1'b0;
      fast_reg <= 1'b0;
      wide_reg <= 1'b0;
      cnt_reg <= 6'h00;
      dmy_reg <= 6'h00;
      sh_reg <= 32'h0000_0000;
      addr_reg <= '0;
      maddr_reg <= '0;
      mrd_reg <= 1'b0;
      pend_reg <= 1'b0;
      byte_reg <= 8'h00;
      sr_reg <= 8'h00;
      bcnt_reg <= 3'h0;
      started_reg <= 1'b0;
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
      drop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sck_prev_reg <= sck_prev_next;
      hold_reg <= hold_next;
      quad_reg <= quad_next;
      fast_reg <= fast_next;
      wide_reg <= wide_next;
      cnt_reg <= cnt_next;
      dmy_reg <= dmy_next;
      sh_reg <= sh_next;
      addr_reg <= addr_next;
      maddr_reg <= maddr_next;
      mrd_reg <= mrd_next;
      pend_reg <= pend_next;
      byte_reg <= byte_next;
      sr_reg <= sr_next;
      bcnt_reg <= bcnt_next;
      started_reg <= started_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      drop_reg <= drop_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.

  assign lk.d_io_o = out_reg;
  assign lk.d_io_oe = oe_reg;
  assign mem_addr = maddr_reg;
  assign mem_rd = mrd_reg;
  assign cmd_dropped = drop_reg;
  assign data_phase = started_reg;
  assign held = hold_reg;
endmodule

`default_nettype wire

//--- src/sfr_flash_host.sv
/*
  Host end of the serial flash link: issues one array read per start pulse
  and hands back each byte, with an optional hold pause.
  Assumes the device answers a falling clock within about six clk periods,
  which is why the half period may not be shorter than eight clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module sfr_flash_host import sfr_pkg::*; #(
  parameter int SCK_HALF = SCK_HALF_DEF,
  parameter int LEN_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  sfr_link_if.host lk,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [31:0] addr,
  input wire logic wide_addr,
  input wire logic quad,
  input wire logic [5:0] dummy_clks,
  input wire logic [LEN_W-1:0] nbytes,
  input wire logic hold_req,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic paused
);

  // Elaboration check: a shorter half period outruns the device's answer.
  if (SCK_HALF < SCK_HALF_MIN || SCK_HALF > 255 || LEN_W < 1) begin : g_bad_param
    $error("SCK_HALF must be 8 to 255 and LEN_W positive");
  end

  logic [3:0] s_io;

  sfr_sync #(.W(4), .INIT(4'hF)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(lk.io),
    .q(s_io)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  sfr_host_st_t state_reg, state_next;
  logic [7:0] ph_reg, ph_next;
  logic sck_reg, sck_next;
  logic cs_n_reg, cs_n_next;
  logic hold_n_reg, hold_n_next;
  logic quad_reg, quad_next;
  logic [39:0] tx_reg, tx_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] dmy_reg, dmy_next;
  logic [LEN_W-1:0] left_reg, left_next;
  logic [7:0] rx_reg, rx_next;
  logic [2:0] bcnt_reg, bcnt_next;
  logic [7:0] data_reg, data_next;
  logic valid_reg, valid_next;
  logic done_reg, done_next;
  logic busy_reg, busy_next;
  logic [3:0] io_o_reg, io_o_next;
  logic [3:0] io_oe_reg, io_oe_next;
  logic advance;
  logic tick;

  // The clock stops low while paused, which the device tolerates.
  assign advance = hold_n_reg & ~(hold_req & ~sck_reg);
  assign tick = advance && (ph_reg == 8'(SCK_HALF - 1));

  always_comb begin
    state_next = state_reg;
    ph_next = ph_reg;
    sck_next = sck_reg;
    cs_n_next = cs_n_reg;
    hold_n_next = hold_n_reg;
    quad_next = quad_reg;
    tx_next = tx_reg;
    cnt_next = cnt_reg;
    dmy_next = dmy_reg;
    left_next = left_reg;
    rx_next = rx_reg;
    bcnt_next = bcnt_reg;
    data_next = data_reg;
    valid_next = 1'b0;
    done_next = 1'b0;
    io_oe_next = io_oe_reg;
    if (state_reg != SFR_H_IDLE && state_reg != SFR_H_DESEL) begin
      ph_next = advance ? (tick ? 8'h00 : ph_reg + 8'h01) : ph_reg;
      // a resume restarts the half period, so the device drives again first.
      if (!hold_n_reg) begin
        ph_next = 8'h00;
      end
      // lower hold only with clock low
      if (!sck_reg) begin
        hold_n_next = ~hold_req;
      end
    end
    case (state_reg)
      SFR_H_IDLE: begin
        hold_n_next = 1'b1;
        if (start) begin
          tx_next = wide_addr ? {opcode, addr} : {opcode, addr[23:0], 8'h00};
          cnt_next = link_clks(quad, CMD_BITS + (wide_addr ? WIDE_ADDR_BITS : SHORT_ADDR_BITS));
          quad_next = quad;
          dmy_next = dummy_clks;
          left_next = (nbytes == '0) ? {{(LEN_W-1){1'b0}}, 1'b1} : nbytes;
          bcnt_next = 3'h0;
          cs_n_next = 1'b0;
          ph_next = 8'h00;
          io_oe_next = quad ? 4'hF : 4'h1;
          state_next = SFR_H_SHIFT;
        end
      end
      SFR_H_SHIFT: begin
        if (tick) begin
          sck_next = ~sck_reg;
          if (sck_reg) begin
            tx_next = quad_reg ? {tx_reg[35:0], 4'h0} : {tx_reg[38:0], 1'b0};
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
              io_oe_next = 4'h0;
              cnt_next = dmy_reg;
              state_next = (dmy_reg == 6'h00) ? SFR_H_DATA : SFR_H_DUMMY;
            end
          end
        end
      end
      SFR_H_DUMMY: begin
        if (tick) begin
          sck_next = ~sck_reg;
          if (sck_reg) begin
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
              state_next = SFR_H_DATA;
            end
          end
        end
      end
      SFR_H_DATA: begin
        if (tick) begin
          sck_next = ~sck_reg;
          if (!sck_reg) begin
            rx_next = quad_reg ? {rx_reg[3:0], s_io} : {rx_reg[6:0], s_io[1]};
            bcnt_next = (bcnt_reg == (quad_reg ? 3'h1 : 3'h7)) ? 3'h0 : bcnt_reg + 3'h1;
            if (bcnt_next == 3'h0) begin
              data_next = rx_next;
              valid_next = 1'b1;
              left_next = left_reg - {{(LEN_W-1){1'b0}}, 1'b1};
            end
          end else if (left_reg == '0) begin
            cs_n_next = 1'b1;
            ph_next = 8'h00;
            state_next = SFR_H_DESEL;
          end
        end
      end
      SFR_H_DESEL: begin
        hold_n_next = 1'b1;
        ph_next = ph_reg + 8'h01;
        if (ph_reg == 8'(SCK_HALF - 1)) begin
          done_next = 1'b1;
          state_next = SFR_H_IDLE;
        end
      end
      default: state_next = SFR_H_IDLE;
    endcase
    io_o_next = quad_reg ? tx_next[39:36] : {3'b000, tx_next[39]};
    if (state_reg == SFR_H_IDLE) begin
      io_o_next = quad ? tx_next[39:36] : {3'b000, tx_next[39]};
    end
    busy_next = state_next != SFR_H_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= SFR_H_IDLE;
      ph_reg <= 8'h00;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      hold_n_reg <= 1'b1;
      quad_reg <= 1'b0;
      tx_reg <= 40'h00_0000_0000;
      cnt_reg <= 6'h00;
      dmy_reg <= 6'h00;
      left_reg <= '0;
      rx_reg <= 8'h00;
      bcnt_reg <= 3'h0;
      data_reg <= 8'h00;
      valid_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      io_o_reg <= 4'h0;
      io_oe_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      ph_reg <= ph_next;
      sck_reg <= sck_next;
      cs_n_reg <= cs_n_next;
      hold_n_reg <= hold_n_next;
      quad_reg <= quad_next;
      tx_reg <= tx_next;
      cnt_reg <= cnt_next;
      dmy_reg <= dmy_next;
      left_reg <= left_next;
      rx_reg <= rx_next;
      bcnt_reg <= bcnt_next;
      data_reg <= data_next;
      valid_reg <= valid_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      io_o_reg <= io_o_next;
      io_oe_reg <= io_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops.

  assign lk.sck = sck_reg;
  assign lk.cs_n = cs_n_reg;
  assign lk.hold_n = hold_n_reg;
  assign lk.h_io_o = io_o_reg;
  assign lk.h_io_oe = io_oe_reg;
  assign busy = busy_reg;
  assign rd_data = data_reg;
  assign rd_valid = valid_reg;
  assign done = done_reg;
  assign paused = ~hold_n_reg;
endmodule

`default_nettype wire

//--- src/sfr_link_if.sv
/*
  Pin bundle between the flash host and the flash device.
  Assumes an undriven data line floats high, as with the usual pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none

interface sfr_link_if;
  logic sck;
  logic cs_n;
  logic hold_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  // Resolved data lines; the device wins a clash, so contention hides behind its data.
  assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o) | (~d_io_oe & ~h_io_oe);

  modport host (output sck, output cs_n, output hold_n, output h_io_o, output h_io_oe,
                input io);
  modport dev (input sck, input cs_n, input hold_n, input io, output d_io_o,
               output d_io_oe);
endinterface

`default_nettype wire

//--- src/sfr_pkg.sv
/*
  Shared constants, types and helpers for both ends of the serial flash read link.
  Assumes nothing beyond a SystemVerilog compiler; no timescale is needed here.
*/
package sfr_pkg;

  // Read opcodes handled by the link.
  localparam logic [7:0] plain_array_read_cmd = 8'h03;
  localparam logic [7:0] plain_array_read_wide_addr_cmd = 8'h13;
  localparam logic [7:0] dummy_cycle_array_read_cmd = 8'h0B;
  localparam logic [7:0] dummy_cycle_array_read_wide_addr_cmd = 8'h0C;
  localparam logic [7:0] quad_io_array_read_cmd = 8'hEB;
  localparam logic [7:0] unique_id_read_cmd = 8'h4B;
  localparam logic [7:0] info_row_read_cmd = 8'h68;

  // Address framing and decoding.
  localparam int ADDR_W = 26;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] SHORT_ADDR_BITS = 6'h18;
  localparam logic [5:0] WIDE_ADDR_BITS = 6'h20;
  localparam int SHORT_VALID_MSB = 23;
  localparam int WIDE_VALID_MSB = 25;

  // Dummy clock defaults and serial clock timing.
  localparam int DUMMY_SINGLE_DEF = 8;
  localparam int DUMMY_QUAD_DEF = 6;
  localparam int SCK_HALF_DEF = 8;
  localparam int SCK_HALF_MIN = 8;

  // Device and host sequencer states.
  typedef enum logic [2:0] {
    SFR_D_CMD, SFR_D_ADDR, SFR_D_DUMMY, SFR_D_DATA, SFR_D_IGNORE
  } sfr_dev_st_t;
  typedef enum logic [2:0] {
    SFR_H_IDLE, SFR_H_SHIFT, SFR_H_DUMMY, SFR_H_DATA, SFR_H_DESEL
  } sfr_host_st_t;

  // Link clocks needed for a number of bits, one or four lanes.
  function automatic logic [5:0] link_clks(input logic quad, input logic [5:0] bits);
    link_clks = quad ? {2'b00, bits[5:2]} : bits;
  endfunction

  // Keeps only the address bits that select a byte of the array.
  function automatic logic [ADDR_W-1:0] addr_mask(input logic wide, input logic [31:0] a);
    addr_mask = wide ? a[WIDE_VALID_MSB:0] : {2'b00, a[SHORT_VALID_MSB:0]};
  endfunction

endpackage

//--- src/sfr_sync.sv
/*
  Two flip-flop synchroniser for a bundle of independent level signals.
  Assumes each bit is a level; bits are not coherent with one another.
*/
`timescale 1ns/1ps
`default_nettype none

module sfr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Elaboration check: an empty bundle has nothing to carry.
  if (W < 1) begin : g_bad_w
    $error("W must be positive");
  end

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= INIT;
      q_reg <= INIT;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

`default_nettype wire
